// *** src/tpc_tieoff_ctrl.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - an output disabled and unpowered by power settings counts as unused
// - an input is unused only when all its internal switches are open
// - used/unused evaluation runs always and cannot be switched off
// - every unused input ties to the reference midrail source
// - unused output ties to 1.5x source if boosted, else reference
// - reference tie-off buffer enabled by register one bit 2
// - boosted tie-off buffer enabled by register one bit 8
// - register 49 bit 0 picks low (0) or high (1) tie impedance
// - tie switches follow used state only, not buffer enables
module tpc_tieoff_ctrl
  import tpc_pkg::*;
(
  input  wire logic                      aclk,            // control clock 40 MHz
  input  wire logic                      aresetn,         // sync reset, low
  input  wire logic [N_IN-1:0][N_SW-1:0] in_switch,       // input switch closures
  input  wire logic [31:0]               s_axi_awaddr,    // write address
  input  wire logic                      s_axi_awvalid,   // write address valid
  output logic                           s_axi_awready,   // write address ready
  input  wire logic [31:0]               s_axi_wdata,     // write data
  input  wire logic [3:0]                s_axi_wstrb,     // write strobes
  input  wire logic                      s_axi_wvalid,    // write data valid
  output logic                           s_axi_wready,    // write data ready
  output logic [1:0]                     s_axi_bresp,     // write response
  output logic                           s_axi_bvalid,    // write response valid
  input  wire logic                      s_axi_bready,    // write response ready
  input  wire logic [31:0]               s_axi_araddr,    // read address
  input  wire logic                      s_axi_arvalid,   // read address valid
  output logic                           s_axi_arready,   // read address ready
  output logic [31:0]                    s_axi_rdata,     // read data
  output logic [1:0]                     s_axi_rresp,     // read response
  output logic                           s_axi_rvalid,    // read data valid
  input  wire logic                      s_axi_rready,    // read data ready
  output logic [N_OUT-1:0]               out_tie_sw_r,    // output tie switch closed
  output logic [N_OUT-1:0]               out_src_boost_r, // output uses 1.5x source
  output logic [N_IN-1:0]                in_tie_sw_r,     // input tie to reference
  output logic                           vref_buf_en_r,   // reference buffer on
  output logic                           boost_buf_en_r,  // 1.5x buffer on
  output logic                           tie_high_imp_r,  // high tie impedance
  output logic [1:0]                     ref_imp_r,       // reference charge impedance
  output logic                           abias_en_r,      // analog bias enable
  output logic                           lv_bias_sel_r    // low-voltage bias select
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [REG_W-1:0] pwr_one_r;
  logic [REG_W-1:0] pwr_three_r;
  logic [REG_W-1:0] boost_ctl_r;
  logic [REG_W-1:0] use_ctl_r;
  logic [31:0]      wa_r;
  logic [31:0]      wd_r;
  logic [3:0]       ws_r;
  logic             wa_ok_r;
  logic             wd_ok_r;
  tpc_out_cfg_t [N_OUT-1:0] out_cfg;
  logic [N_OUT-1:0] eval_out_tie;
  logic [N_OUT-1:0] eval_out_boost;
  logic [N_IN-1:0]  eval_in_tie;
  logic [N_IN-1:0][N_SW-1:0] sw_m_r;
  logic [N_IN-1:0][N_SW-1:0] sw_s_r;
  tpc_tie_t         tie_st;

  function automatic logic [7:0] reg_idx(input logic [31:0] a);
    reg_idx = a[9:2];
  endfunction : reg_idx

  // status word decodes as mapped; writes to it are dropped
  function automatic logic addr_hit(input logic [31:0] a);
    logic [7:0] k;
    k = reg_idx(a);
    addr_hit = (a[1:0] == 2'b00) && (a[31:10] == '0) &&
               (k == IDX_POWER_ENABLE_ONE || k == IDX_POWER_ENABLE_THREE ||
                k == IDX_OUTPUT_BOOST || k == IDX_USE_CONTROL ||
                k == IDX_TIEOFF_STATUS);
  endfunction : addr_hit

  // ---------------------------------------------------------------
  // input synchronisers for pin-side switch states
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sw_m_r <= '0;
      sw_s_r <= '0;
    end
    else
    begin
      // only the second stage feeds the evaluator
      sw_m_r <= in_switch;
      sw_s_r <= sw_m_r;
    end
  end

  // ---------------------------------------------------------------
  // output state from power management
  // ---------------------------------------------------------------
  always_comb
  begin
    out_cfg[0].active  = pwr_three_r[P3_RSPK_EN];
    out_cfg[0].boosted = boost_ctl_r[B49_SPK_BOOST];
    out_cfg[1].active  = pwr_three_r[P3_LSPK_EN];
    out_cfg[1].boosted = boost_ctl_r[B49_SPK_BOOST];
    out_cfg[2].active  = pwr_three_r[P3_LINE2_EN];
    out_cfg[2].boosted = boost_ctl_r[B49_LINE2_BOOST];
    out_cfg[3].active  = pwr_three_r[P3_LINE1_EN];
    out_cfg[3].boosted = boost_ctl_r[B49_LINE1_BOOST];
    // spare output follows the use-control word, never boosted
    out_cfg[4].active  = use_ctl_r[0];
    out_cfg[4].boosted = 1'b0;
  end

  tpc_pin_eval u_eval (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .out_cfg     (out_cfg),
    .in_sw       (sw_s_r),
    .out_tie_r   (eval_out_tie),
    .out_boost_r (eval_out_boost),
    .in_tie_r    (eval_in_tie)
  );

  // ---------------------------------------------------------------
  // tie-off outputs
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_tie_sw_r    <= '1;
      out_src_boost_r <= '0;
      in_tie_sw_r     <= '1;
      vref_buf_en_r   <= 1'b0;
      boost_buf_en_r  <= 1'b0;
      tie_high_imp_r  <= 1'b0;
      ref_imp_r       <= 2'b00;
      abias_en_r      <= 1'b0;
      lv_bias_sel_r   <= 1'b0;
    end
    else
    begin
      out_tie_sw_r    <= eval_out_tie;
      out_src_boost_r <= eval_out_tie & eval_out_boost;
      in_tie_sw_r     <= eval_in_tie;
      vref_buf_en_r   <= pwr_one_r[P1_VREF_BUF];
      boost_buf_en_r  <= pwr_one_r[P1_BOOST_BUF];
      tie_high_imp_r  <= boost_ctl_r[B49_TIE_IMP];
      // bias and reference settings pass straight to the analog side
      ref_imp_r       <= pwr_one_r[P1_REF_IMP_HI:P1_REF_IMP_LO];
      abias_en_r      <= pwr_one_r[P1_ABIAS];
      lv_bias_sel_r   <= pwr_three_r[P3_LV_BIAS];
    end
  end

  always_comb
  begin
    // live tie-off state gathered for the status word
    tie_st.out_tie       = out_tie_sw_r;
    tie_st.out_boost_src = out_src_boost_r;
    tie_st.in_tie        = in_tie_sw_r;
    tie_st.vref_buf_en   = vref_buf_en_r;
    tie_st.boost_buf_en  = boost_buf_en_r;
    tie_st.high_imp      = tie_high_imp_r;
  end

  // ---------------------------------------------------------------
  // axi write channel
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      wa_ok_r       <= 1'b0;
      wd_ok_r       <= 1'b0;
      wa_r          <= '0;
      wd_r          <= '0;
      ws_r          <= '0;
      pwr_one_r     <= REG_RESET;
      pwr_three_r   <= REG_RESET;
      boost_ctl_r   <= REG_RESET;
      use_ctl_r     <= REG_RESET;
    end
    else
    begin
      // ready pulses once per beat and never while a response waits
      s_axi_awready <= !wa_ok_r && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
      s_axi_wready  <= !wd_ok_r && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        wa_r    <= s_axi_awaddr;
        wa_ok_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wd_r    <= s_axi_wdata;
        ws_r    <= s_axi_wstrb;
        wd_ok_r <= 1'b1;
      end
      if (wa_ok_r && wd_ok_r && !s_axi_bvalid)
      begin
        wa_ok_r      <= 1'b0;
        wd_ok_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_hit(wa_r) ? RESP_OKAY : RESP_SLVERR;
        if (addr_hit(wa_r))
        begin
          case (reg_idx(wa_r))
            IDX_POWER_ENABLE_ONE:
            begin
              if (ws_r[0]) pwr_one_r[7:0] <= wd_r[7:0];
              if (ws_r[1]) pwr_one_r[8]   <= wd_r[8];
            end
            IDX_POWER_ENABLE_THREE:
            begin
              if (ws_r[0]) pwr_three_r[7:0] <= wd_r[7:0];
              if (ws_r[1]) pwr_three_r[8]   <= wd_r[8];
            end
            IDX_OUTPUT_BOOST:
            begin
              if (ws_r[0]) boost_ctl_r[7:0] <= wd_r[7:0];
              if (ws_r[1]) boost_ctl_r[8]   <= wd_r[8];
            end
            IDX_USE_CONTROL:
            begin
              if (ws_r[0]) use_ctl_r[7:0] <= wd_r[7:0];
              if (ws_r[1]) use_ctl_r[8]   <= wd_r[8];
            end
            // read-only status and unmapped words ignore writes
            default:
            begin
            end
          endcase
        end
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // axi read channel
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        // bits above bit 8 read as zero, except in the status word, which fills bits 0 to 16
        s_axi_rdata  <= '0;
        case (reg_idx(s_axi_araddr))
          IDX_POWER_ENABLE_ONE:   s_axi_rdata[REG_W-1:0] <= pwr_one_r;
          IDX_POWER_ENABLE_THREE: s_axi_rdata[REG_W-1:0] <= pwr_three_r;
          IDX_OUTPUT_BOOST:       s_axi_rdata[REG_W-1:0] <= boost_ctl_r;
          IDX_USE_CONTROL:        s_axi_rdata[REG_W-1:0] <= use_ctl_r;
          IDX_TIEOFF_STATUS:
          begin
            s_axi_rdata[SW_LSB +: N_OUT]        <= tie_st.out_tie;
            s_axi_rdata[SW_LSB + N_OUT +: N_IN] <= tie_st.in_tie;
            s_axi_rdata[BUF_LSB]                <= tie_st.vref_buf_en;
            s_axi_rdata[BUF_LSB + 1]            <= tie_st.boost_buf_en;
            s_axi_rdata[HIZ_BIT]                <= tie_st.high_imp;
            s_axi_rdata[HIZ_BIT + 1 +: N_OUT]   <= tie_st.out_boost_src;
          end
          default:
          begin
          end
        endcase
        // misaligned or out-of-range reads return zero
        if (!addr_hit(s_axi_araddr))
          s_axi_rdata <= '0;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule : tpc_tieoff_ctrl

// *** src/tpc_pkg.sv ***
package tpc_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_POWER_ENABLE_ONE   = 8'h01;
  localparam logic [7:0] IDX_POWER_ENABLE_THREE = 8'h03;
  localparam logic [7:0] IDX_OUTPUT_BOOST       = 8'h31;
  localparam logic [7:0] IDX_USE_CONTROL        = 8'h40;
  localparam logic [7:0] IDX_TIEOFF_STATUS      = 8'h41;

  localparam int REG_W     = 9;
  localparam int N_OUT     = 5;
  localparam int N_IN      = 4;
  localparam int N_SW      = 4;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int P1_REF_IMP_LO   = 0;
  localparam int P1_REF_IMP_HI   = 1;
  localparam int P1_VREF_BUF     = 2;
  localparam int P1_ABIAS        = 3;
  localparam int P1_BOOST_BUF    = 8;
  localparam int P3_LV_BIAS      = 4;
  localparam int P3_RSPK_EN      = 5;
  localparam int P3_LSPK_EN      = 6;
  localparam int P3_LINE2_EN     = 7;
  localparam int P3_LINE1_EN     = 8;
  localparam int B49_TIE_IMP     = 0;
  localparam int B49_SPK_BOOST   = 2;
  localparam int B49_LINE2_BOOST = 3;
  localparam int B49_LINE1_BOOST = 4;
  localparam int SW_LSB          = 0;
  localparam int BUF_LSB         = 9;
  localparam int HIZ_BIT         = 11;

  localparam logic [REG_W-1:0] REG_RESET = 9'h000;
  localparam logic [1:0]       RESP_OKAY   = 2'b00;
  localparam logic [1:0]       RESP_SLVERR = 2'b10;

  // tie-off source selection per pin
  typedef enum logic [1:0] { TPC_SRC_NONE, TPC_SRC_VREF, TPC_SRC_BOOSTED } tpc_src_t;

  typedef struct packed {
    logic             active;
    logic             boosted;
  } tpc_out_cfg_t;

  typedef struct packed {
    logic [N_OUT-1:0] out_tie;
    logic [N_OUT-1:0] out_boost_src;
    logic [N_IN-1:0]  in_tie;
    logic             vref_buf_en;
    logic             boost_buf_en;
    logic             high_imp;
  } tpc_tie_t;

endpackage : tpc_pkg

// *** src/tpc_pin_eval.sv ***
`timescale 1ns/1ps
module tpc_pin_eval
  import tpc_pkg::*;
(
  input  wire logic                       aclk,        // control clock
  input  wire logic                       aresetn,     // sync reset, low
  input  wire tpc_out_cfg_t [N_OUT-1:0]   out_cfg,     // per output state
  input  wire logic [N_IN-1:0][N_SW-1:0]  in_sw,       // switch closures
  output logic [N_OUT-1:0]                out_tie_r,   // output unused
  output logic [N_OUT-1:0]                out_boost_r, // use boosted source
  output logic [N_IN-1:0]                 in_tie_r     // input unused
);

  // ---------------------------------------------------------------
  // continuous evaluation
  // ---------------------------------------------------------------
  // never gated off
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_tie_r   <= '1;
      out_boost_r <= '0;
      in_tie_r    <= '1;
    end
    else
    begin
      for (int i = 0; i < N_OUT; i++)
      begin
        out_tie_r[i]   <= !out_cfg[i].active;
        out_boost_r[i] <= out_cfg[i].boosted;
      end
      for (int j = 0; j < N_IN; j++)
        in_tie_r[j] <= ~|in_sw[j];
    end
  end

endmodule : tpc_pin_eval

// *** sim/tpc_tieoff_ctrl_sva.sv ***
`timescale 1ns/1ps
module tpc_tieoff_ctrl_sva
  import tpc_pkg::*;
(
  input wire logic                      aclk,            // clock
  input wire logic                      aresetn,         // reset
  input wire logic [N_IN-1:0][N_SW-1:0] in_switch,       // switches
  input wire logic [31:0]               s_axi_awaddr,    // aw addr
  input wire logic                      s_axi_awvalid,   // aw valid
  input wire logic                      s_axi_awready,   // aw ready
  input wire logic [31:0]               s_axi_wdata,     // w data
  input wire logic [3:0]                s_axi_wstrb,     // w strobes
  input wire logic                      s_axi_wvalid,    // w valid
  input wire logic                      s_axi_wready,    // w ready
  input wire logic [1:0]                s_axi_bresp,     // b resp
  input wire logic                      s_axi_bvalid,    // b valid
  input wire logic [N_OUT-1:0]          out_tie_sw_r,    // out tie
  input wire logic [N_OUT-1:0]          out_src_boost_r, // out 1.5x
  input wire logic [N_IN-1:0]           in_tie_sw_r,     // in tie
  input wire logic                      vref_buf_en_r,   // vref buf
  input wire logic                      boost_buf_en_r,  // 1.5x buf
  input wire logic                      tie_high_imp_r,  // high imp
  input wire logic [1:0]                ref_imp_r,       // ref imp
  input wire logic                      abias_en_r,      // bias
  input wire logic                      lv_bias_sel_r    // lv bias
);
  logic [31:0]     aw_q;
  logic [31:0]     wd_q;
  logic [3:0]      ws_q;
  logic [N_IN-1:0] exp_in;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----
  // capture of the write under way
  // ----
  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      aw_q <= s_axi_awaddr;
  end

  always_ff @(posedge aclk)
  begin
    if (s_axi_wvalid && s_axi_wready)
    begin
      wd_q <= s_axi_wdata;
      ws_q <= s_axi_wstrb;
    end
  end

  always_comb
  begin
    for (int i = 0; i < N_IN; i++)
      exp_in[i] = ~|in_switch[i];
  end

  sequence s_wr_ok(a);
    $rose(s_axi_bvalid) && s_axi_bresp == RESP_OKAY && aw_q == a && ws_q[1:0] == 2'h3;
  endsequence

  chk_vref_buf:
    assert property (s_wr_ok(32'h04) |-> ##[1:2] vref_buf_en_r == wd_q[P1_VREF_BUF])
    else $error("vref buffer enable does not follow bit 2");
  chk_boost_buf:
    assert property (s_wr_ok(32'h04) |-> ##[1:2] boost_buf_en_r == wd_q[P1_BOOST_BUF])
    else $error("boosted buffer enable does not follow bit 8");
  chk_tie_imp:
    assert property (s_wr_ok(32'hC4) |-> ##[1:2] tie_high_imp_r == wd_q[B49_TIE_IMP])
    else $error("tie impedance does not follow bit 0");
  chk_out_unused:
    assert property (s_wr_ok(32'h0C) |-> ##[1:3]
      out_tie_sw_r[3:0] == ~wd_q[P3_LINE1_EN:P3_RSPK_EN])
    else $error("output tie does not follow output enables");
  chk_boost_src:
    assert property (s_wr_ok(32'hC4) |-> ##[1:3] out_src_boost_r[3:0] == (out_tie_sw_r[3:0]
      & {wd_q[B49_LINE1_BOOST], wd_q[B49_LINE2_BOOST], wd_q[B49_SPK_BOOST], wd_q[B49_SPK_BOOST]}))
    else $error("boosted source selection wrong");
  chk_src_tied:
    assert property (!(|(out_src_boost_r & ~out_tie_sw_r)))
    else $error("boosted source on an output that is not tied");
  chk_tie_no_buf:
    assert property ($changed({vref_buf_en_r, boost_buf_en_r}) |-> $stable(out_tie_sw_r))
    else $error("tie switches moved with buffer enables");
  chk_in_unused:
    assert property ($stable(in_switch)[*7] |-> in_tie_sw_r == exp_in)
    else $error("input tie does not match switch closures");
  chk_reset_vals:
    assert property ($rose(aresetn) |-> out_tie_sw_r == 5'h1F && in_tie_sw_r == 4'hF
      && !vref_buf_en_r && !boost_buf_en_r && !lv_bias_sel_r)
    else $error("state after reset wrong");
endmodule : tpc_tieoff_ctrl_sva

// *** sim/tb_tpc_tieoff_ctrl.sv ***
`timescale 1ns/1ps
module tb_tpc_tieoff_ctrl
  import tpc_pkg::*;
;
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic [1:0]  r;
    logic [19:0] o;
  } tpc_row_t;

  logic                      aclk;
  logic                      aresetn;
  logic [N_IN-1:0][N_SW-1:0] in_switch;
  logic [31:0]               s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]                s_axi_wstrb;
  logic                      s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                      s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                      s_axi_rvalid, s_axi_rready, vref_buf_en_r, boost_buf_en_r;
  logic                      tie_high_imp_r, abias_en_r, lv_bias_sel_r;
  logic [1:0]                s_axi_bresp, s_axi_rresp, ref_imp_r, r;
  logic [N_OUT-1:0]          out_tie_sw_r, out_src_boost_r;
  logic [N_IN-1:0]           in_tie_sw_r;
  logic [19:0]               obs;
  logic [31:0]               q;
  int                        err_count = 0;
  int                        comparisons = 0;
  // bench-scaled stand-in for the reference charge wait
  localparam int             CHARGE_WAIT = 400;
  // ----
  // address, write data, read data, response, pins
  // ----
  tpc_row_t rows [13] = '{
    '{32'h0C, 32'h010, 32'h010, RESP_OKAY, 20'hF8501},
    '{32'hC4, 32'h01C, 32'h01C, RESP_OKAY, 20'hFFD01},
    '{32'h04, 32'hFFFF_FF04, 32'h104, RESP_OKAY, 20'hFFD61},
    '{32'h04, 32'h10D, 32'h10D, RESP_OKAY, 20'hFFD67},
    '{32'h0C, 32'h1F0, 32'h1F0, RESP_OKAY, 20'h80567},
    '{32'hC4, 32'h019, 32'h019, RESP_OKAY, 20'h80577},
    '{32'h0C, 32'h0B0, 32'h0B0, RESP_OKAY, 20'hD4577},
    '{32'h04, 32'h003, 32'h003, RESP_OKAY, 20'hD451D},
    '{32'h100, 32'h001, 32'h001, RESP_OKAY, 20'h5451D},
    '{32'h200, 32'h1FF, 32'h000, RESP_SLVERR, 20'h5451D},
    '{32'h06, 32'h000, 32'h000, RESP_SLVERR, 20'h5451D},
    '{32'h0C, 32'h010, 32'h010, RESP_OKAY, 20'h7E51D},
    '{32'h104, 32'h1FF, 32'hC94F, RESP_OKAY, 20'h7E51D}};

  assign obs = {out_tie_sw_r, out_src_boost_r[3:0], in_tie_sw_r, vref_buf_en_r, boost_buf_en_r,
                tie_high_imp_r, ref_imp_r, abias_en_r, lv_bias_sel_r};

  tpc_tieoff_ctrl u_tpc_tieoff_ctrl (
    .aclk, .aresetn, .in_switch, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .out_tie_sw_r, .out_src_boost_r, .in_tie_sw_r, .vref_buf_en_r,
    .boost_buf_en_r, .tie_high_imp_r, .ref_imp_r, .abias_en_r, .lv_bias_sel_r
  );

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic note(input logic bad, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (bad)
    begin
      err_count++;
      $display("Error at %0t ns: got 0x%0h expected 0x%0h", $time, g, e);
    end
  endtask : note

  task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
    note(g !== e, g, e);
  endtask : cmp_data

  task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
    note(g !== e, {30'h0, g}, {30'h0, e});
  endtask : cmp_resp

  task automatic cmp_pins(input logic [19:0] g, input logic [19:0] e);
    note(g !== e, {12'h0, g}, {12'h0, e});
  endtask : cmp_pins

  // one transfer; write when wr is set, read otherwise
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic [1:0] rs);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    rd = '0;
    rs = '0;
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid  <= wr;
    s_axi_arvalid <= !wr;
    while (!done && n < 50)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (wr ? s_axi_bvalid : s_axi_rvalid)
      begin
        done = 1'b1;
        rd = s_axi_rdata;
        rs = wr ? s_axi_bresp : s_axi_rresp;
      end
    end
    if (!done)
    begin
      err_count++;
      $display("Error at %0t ns: no bus answer 0x%0h vs 0x%0h", $time, a, d);
      tally_and_finish();
    end
  endtask : bus

  initial
  begin
    repeat (20000) @(posedge aclk);
    err_count++;
    $display("Error at %0t ns: watchdog 0x%0h vs 0x%0h", $time, comparisons, 0);
    tally_and_finish();
  end

  initial
  begin
    aresetn       <= 1'b0;
    in_switch     <= 16'h0208;
    s_axi_awaddr  <= '0;
    s_axi_araddr  <= '0;
    s_axi_wdata   <= '0;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_bready  <= 1'b1;
    s_axi_rready  <= 1'b1;
    repeat (10) @(posedge aclk);
    cmp_pins(obs, 20'hF8780);
    aresetn <= 1'b1;
    @(posedge aclk);
    // no mute path in this block; the bench never unmutes
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, rows[i].d, q, r);
      cmp_resp(r, rows[i].r);
      bus(1'b0, rows[i].a, 32'h0, q, r);
      cmp_data(q, rows[i].q);
      cmp_resp(r, rows[i].r);
      repeat (6) @(posedge aclk);
      cmp_pins(obs, rows[i].o);
      if (rows[i].d == 32'h10D)
        repeat (CHARGE_WAIT) @(posedge aclk);
      $display("row %0d done", i);
    end
    for (int b = 0; b < 17; b++)
    begin
      in_switch <= (b == 16) ? 16'h0 : 16'h0001 << b;
      repeat (10) @(posedge aclk);
      cmp_data({28'h0, in_tie_sw_r}, {28'h0, 4'hF ^ (4'h1 << (b / 4))});
    end
    $display("switch walk done");
    in_switch <= 16'h0208;
    aresetn   <= 1'b0;
    repeat (10) @(posedge aclk);
    cmp_pins(obs, 20'hF8780);
    aresetn <= 1'b1;
    @(posedge aclk);
    bus(1'b0, 32'h0C, 32'h0, q, r);
    cmp_data(q, 32'h0);
    repeat (8) @(posedge aclk);
    cmp_pins(obs, 20'hF8500);
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, rows[k].a, rows[k].d, q, r);
      cmp_resp(r, RESP_OKAY);
    end
    repeat (CHARGE_WAIT) @(posedge aclk);
    cmp_pins(obs, rows[3].o);
    $display("second reset done");
    tally_and_finish();
  end
endmodule : tb_tpc_tieoff_ctrl

bind tpc_tieoff_ctrl tpc_tieoff_ctrl_sva u_tpc_tieoff_ctrl_sva (
  .aclk, .aresetn, .in_switch, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .out_tie_sw_r,
  .out_src_boost_r, .in_tie_sw_r, .vref_buf_en_r, .boost_buf_en_r, .tie_high_imp_r,
  .ref_imp_r, .abias_en_r, .lv_bias_sel_r
);
